// *** hw/flash_ctrl_pkg.sv ***
// Constants, types and timing for the flash erase and sleep controller
package flash_ctrl_pkg;

    localparam logic [7:0] OP_WRITE_ARM = 8'h06;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
    localparam logic [7:0] OP_BLOCK32_WIPE = 8'h52;
    localparam logic [7:0] OP_BLOCK64_WIPE = 8'hD8;
    localparam logic [7:0] OP_CHIP_WIPE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_WIPE_B = 8'hC7;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID = 8'hAB;

    // Bit counts on the link
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] ADDR_END_BITS = 6'h20;
    localparam logic [5:0] ID_START_BITS = 6'h20;
    localparam logic [5:0] BIT_CNT_MAX = 6'h3F;

    // Region sizes as address bit boundaries
    localparam int SECTOR_SHIFT = 12;
    localparam int BLOCK32_SHIFT = 15;
    localparam int BLOCK64_SHIFT = 16;

    // Status byte field positions
    localparam int ST_ACTIVE_POS = 0;
    localparam int ST_LATCH_POS = 1;
    localparam int ST_PROT_POS = 2;

    localparam logic LATCH_RESET = 1'b0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int SECTOR_WIPE_TIME_MS = 150;
    localparam int BLOCK32_WIPE_TIME_MS = 500;
    localparam int BLOCK64_WIPE_TIME_MS = 800;
    localparam int CHIP_WIPE_TIME_MS = 12000;
    localparam int SLEEP_ENTRY_DELAY_US = 3;
    localparam int SLEEP_ENTRY_CYCLES =
        (SLEEP_ENTRY_DELAY_US * CLK_KHZ + 999) / 1000;

    typedef enum logic [1:0] {
        WIPE_SECTOR,
        WIPE_BLOCK32,
        WIPE_BLOCK64,
        WIPE_CHIP
    } wipe_kind_t;

    typedef enum {
        MODE_IDLE,
        MODE_WIPE,
        MODE_SLEEP_WAIT,
        MODE_SLEEP
    } mode_t;

endpackage

// *** hw/pin_sync.sv ***
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_stage1 = d;
        next_q = stage1;
    end

    // Pins idle high so the link looks deselected through reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= '1;
            q <= '1;
        end else begin
            stage1 <= next_stage1;
            q <= next_q;
        end
    end
endmodule

// *** hw/cycle_timer.sv ***
// Down counter that times wipe cycles and the sleep entry delay
`timescale 1ns/1ps
module cycle_timer #(
    parameter int WIDTH = 32
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    output logic running,
    output logic done
);
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] next_count;
    logic next_running;
    logic next_done;

    always_comb begin
        next_count = count;
        next_running = running;
        next_done = 1'b0;
        if (load) begin
            next_count = load_value;
            next_running = 1'b1;
        end else if (running) begin
            if (count <= WIDTH'(1)) begin
                next_running = 1'b0;
                next_done = 1'b1;
            end else begin
                next_count = count - WIDTH'(1);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end else begin
            count <= next_count;
            running <= next_running;
            done <= next_done;
        end
    end
endmodule

// *** hw/flash_erase_sleep_ctrl.sv ***
// Serial command front end for wipes, sleep and wake with ID readout
`timescale 1ns/1ps
module flash_erase_sleep_ctrl #(
    parameter int ADDR_BITS = 20,
    parameter logic [7:0] DEVICE_ID = 8'h5A, // Arbitrary value
    parameter int SECTOR_WIPE_CYCLES =
        flash_ctrl_pkg::SECTOR_WIPE_TIME_MS * flash_ctrl_pkg::CLK_KHZ,
    parameter int BLOCK32_WIPE_CYCLES =
        flash_ctrl_pkg::BLOCK32_WIPE_TIME_MS * flash_ctrl_pkg::CLK_KHZ,
    parameter int BLOCK64_WIPE_CYCLES =
        flash_ctrl_pkg::BLOCK64_WIPE_TIME_MS * flash_ctrl_pkg::CLK_KHZ,
    parameter int CHIP_WIPE_CYCLES =
        flash_ctrl_pkg::CHIP_WIPE_TIME_MS * flash_ctrl_pkg::CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_sel_n,
    input wire logic spi_sck,
    input wire logic spi_din,
    output logic spi_dout,
    output logic spi_dout_oe,
    input wire logic [2:0] protect_range_bits,
    input wire logic ext_busy,
    output logic write_latch_flag,
    output logic op_active_flag,
    output logic sleep_active,
    output logic wipe_start,
    output flash_ctrl_pkg::wipe_kind_t wipe_kind,
    output logic [ADDR_BITS-1:0] wipe_base,
    output logic wipe_done
);

    // Synchronised pins
    logic sel_n_s;
    logic sck_s;
    logic din_s;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .d({spi_sel_n, spi_sck, spi_din}),
        .q({sel_n_s, sck_s, din_s})
    );

    // Link state
    logic sck_d;
    logic sel_n_d;
    logic [5:0] bit_cnt;
    logic [31:0] shifter;
    logic [7:0] opcode;
    logic [2:0] out_idx;
    logic [5:0] next_bit_cnt;
    logic [31:0] next_shifter;
    logic [7:0] next_opcode;
    logic [2:0] next_out_idx;
    logic next_dout;
    logic next_dout_oe;

    // Control state
    flash_ctrl_pkg::mode_t mode;
    flash_ctrl_pkg::mode_t next_mode;
    logic next_write_latch_flag;
    logic next_wipe_start;
    flash_ctrl_pkg::wipe_kind_t next_wipe_kind;
    logic [ADDR_BITS-1:0] next_wipe_base;
    logic timer_load;
    logic [31:0] timer_value;
    logic timer_running;
    logic timer_done;

    logic sck_rise;
    logic sck_fall;
    logic sel_rise;
    logic busy;
    logic asleep;
    logic [7:0] status_byte;
    logic [ADDR_BITS-1:0] frame_addr;
    logic talk_status;
    logic talk_id;

    // Region mask covers the address bits below the region boundary
    function automatic logic [ADDR_BITS-1:0] region_mask(
        input flash_ctrl_pkg::wipe_kind_t kind
    );
        logic [ADDR_BITS-1:0] m;
        m = '1;
        unique case (kind)
            flash_ctrl_pkg::WIPE_SECTOR: begin
                m = ADDR_BITS'((1 << flash_ctrl_pkg::SECTOR_SHIFT) - 1);
            end
            flash_ctrl_pkg::WIPE_BLOCK32: begin
                m = ADDR_BITS'((1 << flash_ctrl_pkg::BLOCK32_SHIFT) - 1);
            end
            flash_ctrl_pkg::WIPE_BLOCK64: begin
                m = ADDR_BITS'((1 << flash_ctrl_pkg::BLOCK64_SHIFT) - 1);
            end
            flash_ctrl_pkg::WIPE_CHIP: begin
                m = '1;
            end
        endcase
        return m;
    endfunction

    // Protection covers the top 2^(bp-1) 64 KB blocks; six or more
    // covers the whole array. Any overlap with the region protects it.
    function automatic logic region_protected(
        input logic [ADDR_BITS-1:0] last_addr,
        input logic [2:0] bp
    );
        logic [ADDR_BITS-1:0] floor_addr;
        logic hit;
        floor_addr = '0;
        hit = 1'b0;
        if (bp >= 3'h6) begin
            hit = 1'b1;
        end else if (bp != 3'h0) begin
            floor_addr = ~ADDR_BITS'(((1 << (bp - 3'h1)) <<
                flash_ctrl_pkg::BLOCK64_SHIFT) - 1);
            hit = last_addr >= floor_addr;
        end
        return hit;
    endfunction

    function automatic logic [31:0] wipe_cycles(
        input flash_ctrl_pkg::wipe_kind_t kind
    );
        logic [31:0] c;
        c = 32'(CHIP_WIPE_CYCLES);
        unique case (kind)
            flash_ctrl_pkg::WIPE_SECTOR: c = 32'(SECTOR_WIPE_CYCLES);
            flash_ctrl_pkg::WIPE_BLOCK32: c = 32'(BLOCK32_WIPE_CYCLES);
            flash_ctrl_pkg::WIPE_BLOCK64: c = 32'(BLOCK64_WIPE_CYCLES);
            flash_ctrl_pkg::WIPE_CHIP: c = 32'(CHIP_WIPE_CYCLES);
        endcase
        return c;
    endfunction

    // Edges come from the second synchroniser stage and its delayed copy
    assign sck_rise = sck_s & ~sck_d & ~sel_n_s;
    assign sck_fall = ~sck_s & sck_d & ~sel_n_s;
    assign sel_rise = sel_n_s & ~sel_n_d;

    assign busy = (mode == flash_ctrl_pkg::MODE_WIPE) | ext_busy;
    assign asleep = (mode == flash_ctrl_pkg::MODE_SLEEP) |
        (mode == flash_ctrl_pkg::MODE_SLEEP_WAIT);
    assign op_active_flag = busy;
    assign sleep_active = (mode == flash_ctrl_pkg::MODE_SLEEP);
    assign frame_addr = shifter[ADDR_BITS-1:0];

    always_comb begin
        status_byte = flash_ctrl_pkg::STATUS_RESET;
        status_byte[flash_ctrl_pkg::ST_ACTIVE_POS] = busy;
        status_byte[flash_ctrl_pkg::ST_LATCH_POS] = write_latch_flag;
        status_byte[flash_ctrl_pkg::ST_PROT_POS +: 3] = protect_range_bits;
    end

    // Status stays readable through wipes, but not in sleep
    assign talk_status = (opcode == flash_ctrl_pkg::OP_STATUS_READ) &&
        (bit_cnt >= flash_ctrl_pkg::OPCODE_BITS) && !asleep;
    assign talk_id = (opcode == flash_ctrl_pkg::OP_WAKE_ID) &&
        (bit_cnt >= flash_ctrl_pkg::ID_START_BITS) && !busy;

    // Link shifter: sample on rising, drive on falling clock edge
    always_comb begin
        next_bit_cnt = bit_cnt;
        next_shifter = shifter;
        next_opcode = opcode;
        next_out_idx = out_idx;
        next_dout = spi_dout;
        next_dout_oe = spi_dout_oe;
        if (sel_n_s) begin
            next_bit_cnt = '0;
            next_out_idx = '0;
            next_dout_oe = 1'b0;
        end else if (sck_rise) begin
            next_shifter = {shifter[30:0], din_s};
            if (bit_cnt != flash_ctrl_pkg::BIT_CNT_MAX) begin
                next_bit_cnt = bit_cnt + 6'h01;
            end
            if (bit_cnt == flash_ctrl_pkg::OPCODE_BITS - 6'h01) begin
                next_opcode = {shifter[6:0], din_s};
            end
        end else if (sck_fall && (talk_status || talk_id)) begin
            // Index wraps so the byte repeats for as long as clocks run
            if (talk_id) begin
                next_dout = DEVICE_ID[3'h7 - out_idx];
            end else begin
                next_dout = status_byte[3'h7 - out_idx];
            end
            next_out_idx = out_idx + 3'h1;
            next_dout_oe = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sck_d <= 1'b0;
            sel_n_d <= 1'b1;
            bit_cnt <= '0;
            shifter <= '0;
            opcode <= '0;
            out_idx <= '0;
            spi_dout <= 1'b0;
            spi_dout_oe <= 1'b0;
        end else begin
            sck_d <= sck_s;
            sel_n_d <= sel_n_s;
            bit_cnt <= next_bit_cnt;
            shifter <= next_shifter;
            opcode <= next_opcode;
            out_idx <= next_out_idx;
            spi_dout <= next_dout;
            spi_dout_oe <= next_dout_oe;
        end
    end

    // Command execution on the select rise that closes a frame
    always_comb begin
        logic addr_frame;
        logic op_frame;
        logic [ADDR_BITS-1:0] mask;
        flash_ctrl_pkg::wipe_kind_t kind;
        logic is_wipe;
        addr_frame = (bit_cnt == flash_ctrl_pkg::ADDR_END_BITS);
        op_frame = (bit_cnt == flash_ctrl_pkg::OPCODE_BITS);
        kind = flash_ctrl_pkg::WIPE_CHIP;
        is_wipe = 1'b0;
        mask = '0;
        next_mode = mode;
        next_write_latch_flag = write_latch_flag;
        next_wipe_start = 1'b0;
        next_wipe_kind = wipe_kind;
        next_wipe_base = wipe_base;
        timer_load = 1'b0;
        timer_value = wipe_cycles(kind);

        unique case (opcode)
            flash_ctrl_pkg::OP_SECTOR_WIPE: begin
                kind = flash_ctrl_pkg::WIPE_SECTOR;
                is_wipe = addr_frame;
            end
            flash_ctrl_pkg::OP_BLOCK32_WIPE: begin
                kind = flash_ctrl_pkg::WIPE_BLOCK32;
                is_wipe = addr_frame;
            end
            flash_ctrl_pkg::OP_BLOCK64_WIPE: begin
                kind = flash_ctrl_pkg::WIPE_BLOCK64;
                is_wipe = addr_frame;
            end
            flash_ctrl_pkg::OP_CHIP_WIPE_A,
            flash_ctrl_pkg::OP_CHIP_WIPE_B: begin
                kind = flash_ctrl_pkg::WIPE_CHIP;
                is_wipe = op_frame;
            end
            default: begin
                is_wipe = 1'b0;
            end
        endcase
        mask = region_mask(kind);

        unique case (mode)
            flash_ctrl_pkg::MODE_IDLE: begin
                if (sel_rise && !ext_busy) begin
                    if (is_wipe && write_latch_flag &&
                        !region_protected(frame_addr | mask,
                            protect_range_bits)) begin
                        next_mode = flash_ctrl_pkg::MODE_WIPE;
                        next_wipe_start = 1'b1;
                        next_wipe_kind = kind;
                        next_wipe_base = frame_addr & ~mask;
                        next_write_latch_flag = 1'b0;
                        timer_load = 1'b1;
                        timer_value = wipe_cycles(kind);
                    end else if (op_frame &&
                        opcode == flash_ctrl_pkg::OP_WRITE_ARM) begin
                        next_write_latch_flag = 1'b1;
                    end else if (op_frame &&
                        opcode == flash_ctrl_pkg::OP_SLEEP) begin
                        next_mode = flash_ctrl_pkg::MODE_SLEEP_WAIT;
                        timer_load = 1'b1;
                        timer_value =
                            32'(flash_ctrl_pkg::SLEEP_ENTRY_CYCLES);
                    end
                end
            end
            flash_ctrl_pkg::MODE_WIPE: begin
                // Sleep and wake opcodes fall through here untouched
                if (timer_done) begin
                    next_mode = flash_ctrl_pkg::MODE_IDLE;
                end
            end
            flash_ctrl_pkg::MODE_SLEEP_WAIT,
            flash_ctrl_pkg::MODE_SLEEP: begin
                // Only the wake opcode is decoded; wipes cannot start here
                if (sel_rise && opcode == flash_ctrl_pkg::OP_WAKE_ID &&
                    bit_cnt >= flash_ctrl_pkg::OPCODE_BITS) begin
                    next_mode = flash_ctrl_pkg::MODE_IDLE;
                end else if (mode == flash_ctrl_pkg::MODE_SLEEP_WAIT &&
                    timer_done) begin
                    next_mode = flash_ctrl_pkg::MODE_SLEEP;
                end
            end
        endcase
    end

    // Reset models power-up: always back in standby
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode <= flash_ctrl_pkg::MODE_IDLE;
            write_latch_flag <= flash_ctrl_pkg::LATCH_RESET;
            wipe_start <= 1'b0;
            wipe_kind <= flash_ctrl_pkg::WIPE_SECTOR;
            wipe_base <= '0;
        end else begin
            mode <= next_mode;
            write_latch_flag <= next_write_latch_flag;
            wipe_start <= next_wipe_start;
            wipe_kind <= next_wipe_kind;
            wipe_base <= next_wipe_base;
        end
    end

    assign wipe_done = timer_done & (mode == flash_ctrl_pkg::MODE_WIPE);

    // One timer serves wipes and sleep entry; they never overlap
    cycle_timer #(
        .WIDTH(32)
    ) u_cycle_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load(timer_load),
        .load_value(timer_value),
        .running(timer_running),
        .done(timer_done)
    );

    logic unused_running;
    assign unused_running = timer_running;

endmodule

// *** testbench/flash_ctrl_properties.sv ***
// Port checker for the erase and sleep controller
`timescale 1ns/1ps
module flash_ctrl_properties #(
    parameter int ADDR_BITS = 20
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spi_sel_n,
    input wire logic spi_sck,
    input wire logic spi_din,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    input wire logic [2:0] protect_range_bits,
    input wire logic ext_busy,
    input wire logic write_latch_flag,
    input wire logic op_active_flag,
    input wire logic sleep_active,
    input wire logic wipe_start,
    input wire flash_ctrl_pkg::wipe_kind_t wipe_kind,
    input wire logic [ADDR_BITS-1:0] wipe_base,
    input wire logic wipe_done
);
    localparam int SLEEP_MIN = 120;
    logic [7:0] hi_cnt;
    logic [7:0] next_hi_cnt;
    logic [ADDR_BITS-1:0] low_mask;

    // Cycles with select high, saturating
    always_comb begin
        next_hi_cnt = hi_cnt;
        if (!spi_sel_n)
            next_hi_cnt = 8'h00;
        else if (hi_cnt != 8'hff)
            next_hi_cnt = hi_cnt + 8'h01;
    end

    always_ff @(posedge sys_clk) begin
        hi_cnt <= sys_rst ? 8'h00 : next_hi_cnt;
    end

    always_comb begin
        case (wipe_kind)
            flash_ctrl_pkg::WIPE_SECTOR: low_mask = ADDR_BITS'(20'h0_0fff);
            flash_ctrl_pkg::WIPE_BLOCK32: low_mask = ADDR_BITS'(20'h0_7fff);
            flash_ctrl_pkg::WIPE_BLOCK64: low_mask = ADDR_BITS'(20'h0_ffff);
            default: low_mask = '1;
        endcase
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_start_clears_latch: assert property (
        wipe_start |-> !write_latch_flag)
        else $error("latch still set at wipe start");
    a_start_sets_busy: assert property (
        wipe_start |-> op_active_flag ##1 op_active_flag [*8])
        else $error("busy flag not held after wipe start");
    a_done_clears_busy: assert property (
        wipe_done |-> ##[1:2] (!op_active_flag || ext_busy))
        else $error("busy flag stuck after wipe end");
    a_start_one_pulse: assert property (
        wipe_start |=> !wipe_start)
        else $error("wipe start longer than one cycle");
    a_chip_unprotected: assert property (
        wipe_start && wipe_kind == flash_ctrl_pkg::WIPE_CHIP
        |-> protect_range_bits == 3'h0)
        else $error("chip wipe with protection set");
    a_base_aligned: assert property (
        wipe_start |-> (wipe_base & low_mask) == '0)
        else $error("wipe base not region aligned");
    a_sleep_entry_delay: assert property (
        $rose(sleep_active) |-> hi_cnt >= SLEEP_MIN)
        else $error("sleep entered before entry delay");
    a_sleep_ignores_cmds: assert property (
        sleep_active |-> !wipe_start && !$rose(write_latch_flag))
        else $error("command acted on while asleep");
    a_busy_no_sleep: assert property (
        op_active_flag && !ext_busy |-> !$rose(sleep_active))
        else $error("sleep entered during a wipe");
    a_busy_follows_ext: assert property (
        ext_busy |-> op_active_flag)
        else $error("busy flag misses other cycle");
    a_oe_released: assert property (
        spi_sel_n [*8] |-> !spi_dout_oe)
        else $error("output driven while deselected");

    c_chip_wipe: cover property (
        wipe_start && wipe_kind == flash_ctrl_pkg::WIPE_CHIP);
    c_sleep: cover property ($rose(sleep_active));
    c_id_out: cover property ($rose(spi_dout_oe));
endmodule

bind flash_erase_sleep_ctrl flash_ctrl_properties #(
    .ADDR_BITS(ADDR_BITS)
) u_props (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sel_n(spi_sel_n),
    .spi_sck(spi_sck), .spi_din(spi_din), .spi_dout(spi_dout),
    .spi_dout_oe(spi_dout_oe), .protect_range_bits(protect_range_bits),
    .ext_busy(ext_busy), .write_latch_flag(write_latch_flag),
    .op_active_flag(op_active_flag), .sleep_active(sleep_active),
    .wipe_start(wipe_start), .wipe_kind(wipe_kind),
    .wipe_base(wipe_base), .wipe_done(wipe_done)
);

// *** testbench/spi_host_model.sv ***
// Behavioural serial host that frames commands to the controller
`timescale 1ns/1ps
module spi_host_model #(
    parameter int WAKE_GAP = 8
) (
    input wire logic sys_clk,
    input wire logic spi_dout,
    input wire logic spi_dout_oe,
    output logic spi_sel_n,
    output logic spi_sck,
    output logic spi_din
);
    logic last_bit = 1'b0;
    // Released line shows the inverse of its last value
    wire logic line = spi_dout_oe ? spi_dout : ~last_bit;

    initial begin
        spi_sel_n = 1'b1;
        spi_sck = 1'b0;
        spi_din = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    // Clock idles low between frames; data read late in high phase
    task automatic xfer(input logic [63:0] tx, input int n,
                        output logic [63:0] rx);
        rx = 64'h0;
        tick(1);
        spi_sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            spi_din = tx[i];
            tick(4);
            spi_sck = 1'b1;
            tick(4);
            last_bit = line;
            rx = {rx[62:0], line};
            spi_sck = 1'b0;
        end
        tick(4);
        spi_sel_n = 1'b1;
        tick(WAKE_GAP);
    endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench for the erase and sleep controller
`timescale 1ns/1ps
module testbench;
    localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary value
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic spi_sel_n, spi_sck, spi_din, spi_dout, spi_dout_oe;
    logic [2:0] protect_range_bits = 3'h0;
    logic ext_busy = 1'b0;
    logic write_latch_flag, op_active_flag, sleep_active;
    logic wipe_start, wipe_done;
    flash_ctrl_pkg::wipe_kind_t wipe_kind;
    logic [19:0] wipe_base;
    logic [19:0] addr;
    logic [63:0] rx;
    logic [21:0] exp_q[$];
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
    int nb;
    int n_mismatch = 0;
    int checks = 0;
    integer seed = 32'h8087_f113;

    always #12.5 sys_clk = ~sys_clk;

    flash_erase_sleep_ctrl #(
        .DEVICE_ID(ID_VAL), .SECTOR_WIPE_CYCLES(400),
        .BLOCK32_WIPE_CYCLES(400), .BLOCK64_WIPE_CYCLES(400),
        .CHIP_WIPE_CYCLES(400)
    ) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .spi_sel_n(spi_sel_n),
        .spi_sck(spi_sck), .spi_din(spi_din), .spi_dout(spi_dout),
        .spi_dout_oe(spi_dout_oe), .protect_range_bits(protect_range_bits),
        .ext_busy(ext_busy), .write_latch_flag(write_latch_flag),
        .op_active_flag(op_active_flag), .sleep_active(sleep_active),
        .wipe_start(wipe_start), .wipe_kind(wipe_kind),
        .wipe_base(wipe_base), .wipe_done(wipe_done)
    );

    spi_host_model u_host (
        .sys_clk(sys_clk), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe),
        .spi_sel_n(spi_sel_n), .spi_sck(spi_sck), .spi_din(spi_din)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic [21:0] exp_of(input logic [7:0] op,
                                           input logic [19:0] a);
        case (op)
            8'h20: return {flash_ctrl_pkg::WIPE_SECTOR, a & 20'hf_f000};
            8'h52: return {flash_ctrl_pkg::WIPE_BLOCK32, a & 20'hf_8000};
            8'hd8: return {flash_ctrl_pkg::WIPE_BLOCK64, a & 20'hf_0000};
            default: return {flash_ctrl_pkg::WIPE_CHIP, 20'h0_0000};
        endcase
    endfunction

    task automatic arm();
        u_host.xfer(64'h06, 8, rx);
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 4000 && op_active_flag !== 1'b0; i++)
            @(posedge sys_clk);
        check(op_active_flag, 1'b0);
    endtask

    // Command that must leave the array untouched
    task automatic refuse(input logic [2:0] bp, input logic do_arm,
                          input logic [31:0] tx, input int n);
        @(posedge sys_clk);
        #2 protect_range_bits = bp;
        if (do_arm)
            arm();
        u_host.xfer({32'h0, tx}, n, rx);
        repeat (8) @(posedge sys_clk);
        check(op_active_flag, 1'b0);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Every wipe start must match the oldest note
    always @(negedge sys_clk) begin
        if (!sys_rst && wipe_start === 1'b1) begin
            if (exp_q.size() == 0)
                check(1'b1, 1'b0);
            else
                check({wipe_kind, wipe_base}, exp_q.pop_front());
        end
    end

    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        check(sleep_active, 1'b0);
        check(write_latch_flag, 1'b0);
        #2 ext_busy = 1'b1;
        @(posedge sys_clk);
        #2 check(op_active_flag, 1'b1);
        // Released line toggles in the model, so no ID byte can appear
        u_host.xfer({16'h0, 8'hab, 40'h0}, 48, rx);
        check(rx[15:0] == {ID_VAL, ID_VAL}, 1'b0);
        u_host.xfer({56'h0, 8'hb9}, 8, rx);
        repeat (130) @(posedge sys_clk);
        check(sleep_active, 1'b0);
        #2 ext_busy = 1'b0;
        $display("test reset done");
        refuse(3'h0, 1'b0, 32'h2001_2345, 32);
        refuse(3'h0, 1'b1, 32'h1000_91a2, 31);
        refuse(3'h0, 1'b1, 32'h0000_00c1, 9);
        refuse(3'h1, 1'b1, 32'h200f_2345, 32);
        refuse(3'h7, 1'b1, 32'hd80f_0000, 32);
        refuse(3'h1, 1'b1, 32'h0000_00c7, 8);
        #2 protect_range_bits = 3'h0;
        $display("test refusals done");
        foreach (ops[i]) begin
            addr = 20'($random(seed));
            arm();
            check(write_latch_flag, 1'b1);
            exp_q.push_back(exp_of(ops[i], addr));
            nb = (ops[i] inside {8'h60, 8'hc7}) ? 8 : 32;
            u_host.xfer(nb == 8 ? {56'h0, ops[i]} :
                        {32'h0, ops[i], 4'h0, addr}, nb, rx);
            u_host.xfer({48'h0, 8'h05, 8'h00}, 16, rx);
            check(rx[7:0], 8'h01);
            u_host.xfer({56'h0, 8'hb9}, 8, rx);
            wait_idle();
        end
        repeat (130) @(posedge sys_clk);
        check(sleep_active, 1'b0);
        check(32'(exp_q.size()), 0);
        $display("test wipes done");
        u_host.xfer({56'h0, 8'hb9}, 8, rx);
        repeat (130) @(posedge sys_clk);
        check(sleep_active, 1'b1);
        arm();
        check(write_latch_flag, 1'b0);
        u_host.xfer({16'h0, 8'hab, 40'h0}, 48, rx);
        check(rx[15:0], {ID_VAL, ID_VAL});
        check(sleep_active, 1'b0);
        $display("test sleep and wake done");
        u_host.xfer({56'h0, 8'hb9}, 8, rx);
        repeat (130) @(posedge sys_clk);
        u_host.xfer({56'h0, 8'hab}, 8, rx);
        check(sleep_active, 1'b0);
        u_host.xfer({56'h0, 8'hb9}, 8, rx);
        repeat (130) @(posedge sys_clk);
        check(sleep_active, 1'b1);
        #2 sys_rst = 1'b1;
        repeat (5) @(posedge sys_clk);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        check(sleep_active, 1'b0);
        $display("test reset in sleep done");
        final_report();
    end
endmodule
